// ### inc/dsf_map.svh
`ifndef DSF_MAP_SVH
`define DSF_MAP_SVH
// ****************************************
// bus offsets (byte addresses)
// ****************************************
`define DSF_OFS_CTRL      4'h0
`define DSF_OFS_STATUS    4'h4
`define DSF_OFS_FRAME     4'h8
`define DSF_OFS_DACCODE   4'hC
// ****************************************
// frame field positions
// ****************************************
`define DSF_SLIP_BIT      31
`define DSF_DEVADR_HI     30
`define DSF_DEVADR_LO     29
`define DSF_REGADR_HI     28
`define DSF_REGADR_LO     24
`define DSF_DATA_HI       23
`define DSF_DATA_LO       8
`define DSF_CRC_HI        7
`define DSF_CRC_LO        0
`define DSF_FRAME_LONG    6'h20
`define DSF_FRAME_SHORT   6'h18
`define DSF_CRC_POLY      8'h07
// ****************************************
// decoded register addresses and fields
// ****************************************
`define DSF_REG_DACCODE   5'h01
`define DSF_REG_SETUP     5'h06
`define DSF_REG_GENSETUP  5'h07
`define DSF_REG_SUPPLY    5'h08
`define DSF_REG_SWRESET   5'h0E
`define DSF_SWRESET_KEY   16'hABCD
`define DSF_RST_CRC_EN    1'b1
`define DSF_RST_DEVADR    2'h0
`endif

// ### inc/dsf_pkg.sv
package dsf_pkg;
    // output mode, one-hot so that two modes can never be both set
    typedef enum logic [1:0]
    {
        DSF_OUT_OFF  = 2'h0,
        DSF_OUT_VOLT = 2'h1,
        DSF_OUT_CURR = 2'h2
    } dsf_mode_t;
    // serial receive state, gray along idle-shift-done
    typedef enum logic [1:0]
    {
        DSF_IDLE  = 2'h0,
        DSF_SHIFT = 2'h1,
        DSF_DONE  = 2'h3
    } dsf_state_t;
endpackage

// ### rtl/dsf_crc8.sv
`timescale 1ns/1ps
`include "dsf_map.svh"
// serial crc-8 over one bit per enable, msb first
module dsf_crc8
(
    input  wire logic       clock,   // system clock
    input  wire logic       arst_n,  // async reset, low
    input  wire logic       clr,     // restart checksum
    input  wire logic       en,      // one data bit present
    input  wire logic       din,     // data bit
    output logic [7:0]      crc      // running checksum
);
    logic fb;                        // feedback bit
    assign fb = crc[7] ^ din;
    // shift register with polynomial feedback
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            crc <= 8'h00;
        else if (clr)
            crc <= 8'h00;
        else if (en)
            crc <= {crc[6:0], 1'b0} ^ (fb ? `DSF_CRC_POLY : 8'h00);
    end
endmodule

// ### rtl/dsf_rx.sv
`timescale 1ns/1ps
// Behaviour
// - checksum on at reset, 32-bit frames
// - msb first, sampled on falling sclk
// - checksum off: 24 bits used, extra ignored
// - slip, device, register, data, checksum fields
// - dac code kept as straight binary
// - voltage and current modes never both on
// - six current ranges selectable
// - four voltage ranges selectable
// - setup bit adds twenty percent overrange
// - general setup bit offsets unipolar ranges negatively
// - strobe high blocks output register update
// - dynamic tracking mode selectable
// - fixed supply level held from software
// - configuration sent over three-wire interdie link
// - outputs disabled after any reset
`include "dsf_map.svh"
module dsf_rx
(
    input  wire logic        clock,              // 20 MHz system clock
    input  wire logic        arst_n,             // async reset, low
    input  wire logic        sclk,               // serial clock pin
    input  wire logic        sync_n,             // chip select pin, low
    input  wire logic        sdin,               // serial data pin
    input  wire logic        load_dac_strobe,    // load strobe pin, high holds
    input  wire logic [3:0]  avs_address,        // avalon byte address
    input  wire logic        avs_read,           // avalon read
    input  wire logic        avs_write,          // avalon write
    input  wire logic [31:0] avs_writedata,      // avalon write data
    output logic [31:0]      avs_readdata,       // avalon read data
    output logic             avs_waitrequest,    // avalon wait
    output logic             volt_en,            // voltage stage on
    output logic             curr_en,            // current stage on
    output logic [2:0]       range_sel,          // selected output range
    output logic             overrange_en,       // twenty percent overrange
    output logic             neg_offset_en,      // unipolar negative offset
    output logic             dynamic_supply_tracking, // tracking mode on
    output logic [4:0]       fixed_supply_setting,    // fixed supply level
    output logic [15:0]      dac_out,            // straight binary code
    output logic             link_clk,           // interdie clock
    output logic             link_cs_n,          // interdie select, low
    output logic             link_dat            // interdie data
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [1:0] sclk_s_q;                        // sclk two-stage
    logic [1:0] cs_s_q;                          // select two-stage
    logic [1:0] sd_s_q;                          // data two-stage
    logic [1:0] ld_s_q;                          // strobe two-stage
    logic       sclk_old_q;                      // last synced sclk
    logic       cs_old_q;                        // last synced select
    // only stage one feeds stage two; edges use stage two
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sclk_s_q   <= 2'h0;
            cs_s_q     <= 2'h3;
            sd_s_q     <= 2'h0;
            ld_s_q     <= 2'h3;
            sclk_old_q <= 1'b0;
            cs_old_q   <= 1'b1;
        end
        else
        begin
            sclk_s_q   <= {sclk_s_q[0], sclk};
            cs_s_q     <= {cs_s_q[0], sync_n};
            sd_s_q     <= {sd_s_q[0], sdin};
            ld_s_q     <= {ld_s_q[0], load_dac_strobe};
            sclk_old_q <= sclk_s_q[1];
            cs_old_q   <= cs_s_q[1];
        end
    end
    // sampling through a 20 MHz clock limits sclk to a few MHz here,
    // well under what the host may legally run
    wire sclk_fall = sclk_old_q & ~sclk_s_q[1];
    wire cs_fall   = cs_old_q & ~cs_s_q[1];
    wire cs_rise   = ~cs_old_q & cs_s_q[1];
    wire cs_low    = ~cs_s_q[1];
    // ****************************************
    // frame shift register
    // ****************************************
    dsf_pkg::dsf_state_t st_q;                   // receive state
    dsf_pkg::dsf_state_t st_d;                   // next state
    logic [31:0] sh_q;                           // input shift register
    logic [5:0]  cnt_q;                          // bits received
    logic        crc_en_q;                       // checksum protection
    logic [31:0] last_q;                         // last accepted frame
    logic [7:0]  crc_val;                        // running checksum
    logic        good_cnt_q;                     // frames accepted count lsb
    logic        bad_q;                          // sticky checksum or length error
    wire take_bit  = (st_q == dsf_pkg::DSF_SHIFT) && cs_low && sclk_fall && (cnt_q != `DSF_FRAME_LONG);
    wire crc_bit   = take_bit && (cnt_q < `DSF_FRAME_SHORT);
    // frame aligned into bits 31:8 regardless of length
    wire [31:0] frm = crc_en_q ? sh_q : {sh_q[23:0], 8'h00};
    wire len_ok    = crc_en_q ? (cnt_q == `DSF_FRAME_LONG) : (cnt_q >= `DSF_FRAME_SHORT);
    wire crc_ok    = ~crc_en_q || (crc_val == sh_q[`DSF_CRC_HI:`DSF_CRC_LO]);
    wire dev_ok    = frm[`DSF_DEVADR_HI:`DSF_DEVADR_LO] == `DSF_RST_DEVADR;
    wire accept    = (st_q == dsf_pkg::DSF_DONE) && len_ok && crc_ok && dev_ok;
    wire reject    = (st_q == dsf_pkg::DSF_DONE) && !(len_ok && crc_ok);
    wire [4:0]  f_reg  = frm[`DSF_REGADR_HI:`DSF_REGADR_LO];
    wire [15:0] f_data = frm[`DSF_DATA_HI:`DSF_DATA_LO];
    // state sequence: wait select low, shift, act at select high
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            dsf_pkg::DSF_IDLE:  if (cs_fall) st_d = dsf_pkg::DSF_SHIFT;
            dsf_pkg::DSF_SHIFT: if (cs_rise) st_d = dsf_pkg::DSF_DONE;
            dsf_pkg::DSF_DONE:  st_d = dsf_pkg::DSF_IDLE;
            default:            st_d = dsf_pkg::DSF_IDLE;
        endcase
    end
    // shift msb first; count holds at 32 so extra bits are ignored
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q  <= dsf_pkg::DSF_IDLE;
            sh_q  <= 32'h0000_0000;
            cnt_q <= 6'h00;
        end
        else
        begin
            st_q <= st_d;
            if (cs_fall)
                cnt_q <= 6'h00;
            else if (take_bit)
            begin
                cnt_q <= cnt_q + 6'h01;
                if (crc_en_q || cnt_q < `DSF_FRAME_SHORT)
                    sh_q <= {sh_q[30:0], sd_s_q[1]};
            end
        end
    end
    dsf_crc8 u_crc
    (
        .clock  (clock),
        .arst_n (arst_n),
        .clr    (cs_fall),
        .en     (crc_bit),
        .din    (sd_s_q[1]),
        .crc    (crc_val)
    );
    // ****************************************
    // device configuration from frames
    // ****************************************
    logic [15:0] code_q;                         // input code register
    logic        soft_rst_q;                     // software reset pulse
    wire w_code   = accept && f_reg == `DSF_REG_DACCODE;
    wire w_setup  = accept && f_reg == `DSF_REG_SETUP;
    wire w_gen    = accept && f_reg == `DSF_REG_GENSETUP;
    wire w_supply = accept && f_reg == `DSF_REG_SUPPLY;
    wire w_swrst  = accept && f_reg == `DSF_REG_SWRESET && f_data == `DSF_SWRESET_KEY;
    // setup: [1:0] mode, [4:2] range, [5] overrange; gen: [0] offset, [1] crc
    wire [1:0] mode_req = f_data[1:0];
    // both bits set is refused as mode off
    wire v_req = mode_req == dsf_pkg::DSF_OUT_VOLT;
    wire c_req = mode_req == dsf_pkg::DSF_OUT_CURR;
    // voltage mode only has four ranges, top bit cleared
    wire [2:0] rng_req = c_req ? ((f_data[4:2] > 3'h5) ? 3'h0 : f_data[4:2]) : {1'b0, f_data[3:2]};
    // config registers; software reset re-enters defaults
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            volt_en                 <= 1'b0;
            curr_en                 <= 1'b0;
            range_sel               <= 3'h0;
            overrange_en            <= 1'b0;
            neg_offset_en           <= 1'b0;
            crc_en_q                <= `DSF_RST_CRC_EN;
            dynamic_supply_tracking <= 1'b0;
            fixed_supply_setting    <= 5'h00;
            code_q                  <= 16'h0000;
            soft_rst_q              <= 1'b0;
        end
        else if (soft_rst_q)
        begin
            volt_en                 <= 1'b0;
            curr_en                 <= 1'b0;
            range_sel               <= 3'h0;
            overrange_en            <= 1'b0;
            neg_offset_en           <= 1'b0;
            crc_en_q                <= `DSF_RST_CRC_EN;
            dynamic_supply_tracking <= 1'b0;
            fixed_supply_setting    <= 5'h00;
            code_q                  <= 16'h0000;
            soft_rst_q              <= 1'b0;
        end
        else
        begin
            soft_rst_q <= w_swrst;
            if (w_setup)
            begin
                volt_en      <= v_req;
                curr_en      <= c_req;
                range_sel    <= rng_req;
                overrange_en <= f_data[5];
            end
            if (w_gen)
            begin
                neg_offset_en <= f_data[0];
                crc_en_q      <= f_data[1];
            end
            if (w_supply)
            begin
                dynamic_supply_tracking <= f_data[5];
                fixed_supply_setting    <= f_data[4:0];
            end
            if (w_code)
                code_q <= f_data;
        end
    end
    // output register follows code only while strobe is low
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            dac_out <= 16'h0000;
        else if (soft_rst_q)
            dac_out <= 16'h0000;
        else if (!ld_s_q[1])
            dac_out <= code_q;
    end
    // ****************************************
    // interdie three-wire forwarder
    // ****************************************
    logic [22:0] lk_sh_q;                    // reg address and data
    logic [4:0]  lk_cnt_q;                   // bits left
    logic        lk_div_q;                   // clock divider phase
    // a config frame is forwarded; a frame during a send is dropped
    wire lk_start = (w_setup | w_gen | w_supply) && lk_cnt_q == 5'h00;
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lk_sh_q   <= 23'h000000;
            lk_cnt_q  <= 5'h00;
            lk_div_q  <= 1'b0;
            link_clk  <= 1'b0;
            link_cs_n <= 1'b1;
            link_dat  <= 1'b0;
        end
        else if (lk_start)
        begin
            lk_sh_q   <= {2'h0, f_reg, f_data};
            lk_cnt_q  <= 5'h17;
            lk_div_q  <= 1'b0;
            link_cs_n <= 1'b0;
        end
        else if (lk_cnt_q != 5'h00)
        begin
            lk_div_q <= ~lk_div_q;
            link_clk <= lk_div_q;
            if (!lk_div_q)
            begin
                link_dat <= lk_sh_q[22];
                lk_sh_q  <= {lk_sh_q[21:0], 1'b0};
            end
            else
                lk_cnt_q <= lk_cnt_q - 5'h01;
        end
        else
        begin
            link_clk  <= 1'b0;
            link_cs_n <= 1'b1;
        end
    end
    // ****************************************
    // avalon slave, one wait cycle per access
    // ****************************************
    logic        ack_q;                      // answer phase
    wire req      = avs_read | avs_write;
    wire hit_ctrl = avs_address == `DSF_OFS_CTRL;
    wire [31:0] rd_mux =
        hit_ctrl                         ? {30'h0, neg_offset_en, crc_en_q} :
        (avs_address == `DSF_OFS_STATUS) ? {26'h0, curr_en, volt_en, good_cnt_q, bad_q, 1'b0, ld_s_q[1]} :
        (avs_address == `DSF_OFS_FRAME)  ? last_q :
        (avs_address == `DSF_OFS_DACCODE)? {16'h0, dac_out} : 32'h0000_0000;
    // waitrequest high until the second cycle of a request
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ack_q           <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
            last_q          <= 32'h0000_0000;
            good_cnt_q      <= 1'b0;
            bad_q           <= 1'b0;
        end
        else
        begin
            ack_q           <= req & ~ack_q;
            avs_waitrequest <= ~(req & ~ack_q);
            if (req & ~ack_q)
                avs_readdata <= rd_mux;
            if (accept)
            begin
                last_q     <= frm;
                good_cnt_q <= ~good_cnt_q;
            end
            // set wins over a software clear in the same cycle
            if (reject)
                bad_q <= 1'b1;
            else if (avs_write && ack_q && hit_ctrl && avs_writedata[8])
                bad_q <= 1'b0;
        end
    end
endmodule

// ### test/dsf_host.sv
`timescale 1ns/1ps
// ****************************************
// host side serial master
// ****************************************
module dsf_host
(
    input  wire logic clock,  // system clock
    output logic      sclk,   // serial clock, idles high between frames
    output logic      sync_n, // frame select, low
    output logic      sdin    // serial data
);
    initial
    begin
        sclk = 1'b1;
        sync_n = 1'b1;
        sdin = 1'b0;
    end
    // eight clocks a bit keeps sclk far below the ceiling and the receiver's sync
    task automatic send(input logic [31:0] f, input int nb);
        @(posedge clock);
        sync_n <= 1'b0;
        for (int i = 31; i > 31 - nb; i--)
        begin
            sdin <= f[i];
            repeat (4) @(posedge clock);
            sclk <= 1'b0;
            repeat (4) @(posedge clock);
            sclk <= 1'b1;
        end
        repeat (4) @(posedge clock);
        sync_n <= 1'b1;
        sdin <= ~sdin; // a released line never shows the last bit
        repeat (8) @(posedge clock);
    endtask
    // quiet time after any reset event, 10000 system clocks long
    task automatic settle();
        repeat (10000) @(posedge clock);
    endtask
endmodule

// ### test/dsf_rx_chk.sv
`timescale 1ns/1ps
// ****************************************
// pin-level checker
// ****************************************
module dsf_rx_chk
(
    input wire logic        clock,                   // system clock
    input wire logic        arst_n,                  // async reset, low
    input wire logic        sync_n,                  // frame select
    input wire logic        load_dac_strobe,         // output hold strobe
    input wire logic        avs_read,                // bus read
    input wire logic        avs_write,               // bus write
    input wire logic        avs_waitrequest,         // bus wait
    input wire logic        volt_en,                 // voltage stage
    input wire logic        curr_en,                 // current stage
    input wire logic [2:0]  range_sel,               // range
    input wire logic        dynamic_supply_tracking, // tracking mode
    input wire logic [4:0]  fixed_supply_setting,    // supply level
    input wire logic [15:0] dac_out,                 // output code
    input wire logic        link_clk,                // interdie clock
    input wire logic        link_cs_n                // interdie select
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    // 23 bits at half rate, a little slack for framing
    sequence s_link_end; ##[40:56] $rose(link_cs_n); endsequence
    sequence s_strobe_held; load_dac_strobe [*4]; endsequence
    property p_one_mode; !(volt_en && curr_en); endproperty
    property p_en_rise; ($rose(volt_en) || $rose(curr_en)) |-> sync_n; endproperty
    property p_strobe; s_strobe_held |=> $stable(dac_out); endproperty
    property p_curr_rng; curr_en |-> range_sel <= 3'h5; endproperty
    property p_volt_rng; volt_en |-> !range_sel[2]; endproperty
    property p_supply; ($changed(fixed_supply_setting) || $changed(dynamic_supply_tracking)) |-> sync_n; endproperty
    property p_link_len; $fell(link_cs_n) |-> s_link_end; endproperty
    property p_link_idle; link_cs_n [*4] |-> $stable(link_clk); endproperty
    property p_wait_one; $fell(avs_waitrequest) |=> avs_waitrequest; endproperty
    property p_wait_cause; !avs_waitrequest |-> $past(avs_read || avs_write); endproperty
    property p_rst_off; $rose(arst_n) |-> !volt_en && !curr_en; endproperty
    a_one_mode: assert property (p_one_mode) else $error("both output stages on");
    a_en_rise: assert property (p_en_rise) else $error("stage enabled inside a frame");
    a_rst_off: assert property (p_rst_off) else $error("stage on straight after reset");
    a_strobe: assert property (p_strobe) else $error("output moved while strobe high");
    a_curr_rng: assert property (p_curr_rng) else $error("current range out of set");
    a_volt_rng: assert property (p_volt_rng) else $error("voltage range out of set");
    a_supply: assert property (p_supply) else $error("supply changed inside a frame");
    a_link_len: assert property (p_link_len) else $error("interdie frame length wrong");
    a_link_idle: assert property (p_link_idle) else $error("interdie clock runs while idle");
    a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
    a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
endmodule
bind dsf_rx dsf_rx_chk dsf_rx_chk_inst (.clock, .arst_n, .sync_n, .load_dac_strobe, .avs_read, .avs_write,
    .avs_waitrequest, .volt_en, .curr_en, .range_sel, .dynamic_supply_tracking, .fixed_supply_setting,
    .dac_out, .link_clk, .link_cs_n);

// ### test/dsf_rx_tb.sv
`timescale 1ns/1ps
module dsf_rx_tb;
    logic clock = 1'b0, arst_n = 1'b0, load_dac_strobe = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, m_last;
    logic avs_waitrequest, volt_en, curr_en, overrange_en, neg_offset_en, dynamic_supply_tracking;
    logic link_clk, link_cs_n, link_dat, sclk, sync_n, sdin;
    logic [2:0] range_sel;
    logic [4:0] fixed_supply_setting;
    logic [15:0] dac_out, v;
    int n_mismatch = 0, compares = 0;
    int m_mode, m_rng, m_ovr, m_neg, m_crc, m_lvl, m_dyn, m_code, m_out, m_bad;
    logic [22:0] lk_q, m_link;
    int lk_n = 0, n_lk = 0, m_nlink = 0;
    integer seed = 32'h3fb5;
    always #25 clock = ~clock;
    dsf_rx dsf_rx_inst (.clock, .arst_n, .sclk, .sync_n, .sdin, .load_dac_strobe, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .volt_en, .curr_en, .range_sel,
        .overrange_en, .neg_offset_en, .dynamic_supply_tracking, .fixed_supply_setting, .dac_out,
        .link_clk, .link_cs_n, .link_dat);
    dsf_host dsf_host_inst (.clock, .sclk, .sync_n, .sdin);
    // interdie far side: bits taken on rising link clock, word checked at select rise
    always @(negedge link_cs_n) lk_n = 0;
    always @(posedge link_clk)
    begin
        if (!link_cs_n)
        begin
            lk_q = {lk_q[21:0], link_dat};
            lk_n++;
        end
    end
    always @(posedge link_cs_n)
    begin
        if (arst_n)
        begin
            n_lk++;
            chk("link_word", m_link, lk_q);
            chk("link_bits", 23, lk_n);
        end
    end
    // ****************************************
    // reference model
    // ****************************************
    function automatic logic [7:0] crc8(input logic [23:0] b);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    function automatic logic [31:0] mk(input logic [4:0] r, input logic [15:0] d);
        return {3'b000, r, d, crc8({3'b000, r, d})};
    endfunction
    function automatic void m_reset();
        {m_mode, m_rng, m_ovr, m_neg, m_lvl, m_dyn, m_code} = '0;
        m_crc = 1;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (e !== g)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic summarize();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // one bus access; the request stands until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        for (k = 0; k < 20; k++)
        begin
            @(posedge clock);
            if (avs_waitrequest === 1'b0) break;
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (k == 20)
        begin
            chk("waitrequest", 0, 1);
            summarize();
        end
    endtask
    // send a frame and apply it to the model
    task automatic frame(input logic [31:0] f, input int nb);
        logic [23:0] p;
        p = f[31:8];
        dsf_host_inst.send(f, nb);
        if (m_crc != 0 && (nb != 32 || crc8(p) !== f[7:0])) m_bad = 1;
        else if (nb >= 24 && p[22:21] == 2'b00)
        begin
            m_last = m_crc ? f : {p, 8'h00};
            case (p[20:16])
                5'h01: m_code = p[15:0];
                5'h06:
                begin
                    m_mode = p[1:0];
                    m_rng  = p[4:2];
                    m_ovr  = p[5];
                end
                5'h07:
                begin
                    m_crc = p[1];
                    m_neg = p[0];
                end
                5'h08:
                begin
                    m_dyn = p[5];
                    m_lvl = p[4:0];
                end
                5'h0E: if (p[15:0] == 16'hABCD) m_reset();
                default: ;
            endcase
            // config frames are forwarded over the interdie link
            if (p[20:16] == 5'h06 || p[20:16] == 5'h07 || p[20:16] == 5'h08)
            begin
                m_link = p[22:0];
                m_nlink++;
            end
        end
        if (!load_dac_strobe) m_out = m_code;
    endtask
    task automatic outs();
        chk("volt_en", m_mode == 1, volt_en);
        chk("curr_en", m_mode == 2, curr_en);
        if (m_mode == 1) chk("range_v", m_rng & 3, range_sel);
        if (m_mode == 2) chk("range_c", m_rng > 5 ? 0 : m_rng, range_sel);
        chk("overrange", m_ovr, overrange_en);
        chk("neg_offset", m_neg, neg_offset_en);
        chk("supply", m_lvl, fixed_supply_setting);
        chk("tracking", m_dyn, dynamic_supply_tracking);
        chk("dac_out", m_out, dac_out);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        m_reset();
        {m_out, m_bad} = '0;
        repeat (8) @(posedge clock);
        arst_n <= 1'b1;
        chk("link_cs_n", 1, link_cs_n);
        outs();
        bus(0, 4'h0, 0);
        chk("ctrl", 1, rd[1:0]);
        dsf_host_inst.settle();
        for (int r = 0; r < 16; r++)
        begin
            frame(mk(5'h06, {10'h000, r[0], r[2:0], r[3] ? 2'h2 : 2'h1}), 32);
            outs();
        end
        frame(mk(5'h01, 16'h1234) ^ 32'h1, 32);
        frame(mk(5'h01, 16'h5678), 24);
        outs();
        bus(0, 4'h4, 0);
        chk("bad", m_bad, rd[2]);
        bus(1, 4'h0, 32'h100);
        bus(0, 4'h4, 0);
        chk("bad_clear", 0, rd[2]);
        v = 16'($random(seed));
        frame(mk(5'h01, v), 32);
        outs();
        bus(0, 4'hC, 0);
        chk("code_rd", m_out, rd);
        bus(0, 4'h8, 0);
        chk("frame", m_last, rd);
        @(posedge clock) load_dac_strobe <= 1'b1;
        frame(mk(5'h01, ~v), 32);
        outs();
        @(posedge clock) load_dac_strobe <= 1'b0;
        repeat (6) @(posedge clock);
        m_out = m_code;
        outs();
        frame(mk(5'h08, 16'($random(seed)) & 16'h003F), 32);
        outs();
        frame(mk(5'h07, 16'h0001), 32);
        bus(0, 4'h0, 0);
        chk("ctrl", 2, rd[1:0]);
        frame({3'b000, 5'h01, 16'hA5C3, 8'h00}, 24);
        bus(0, 4'h8, 0);
        chk("frame", m_last, rd);
        frame({3'b000, 5'h01, 16'h3C5A, 8'hFF}, 32);
        outs();
        frame({3'b000, 5'h01, 16'h0F0F, 8'h00}, 16);
        frame({3'b010, 5'h01, 16'hFFFF, 8'h00}, 24);
        frame({3'b000, 5'h06, 16'h0003, 8'h00}, 24);
        outs();
        bus(1, 4'h2, 32'hFFFFFFFF);
        bus(0, 4'h2, 0);
        chk("unmapped", 0, rd);
        frame({3'b000, 5'h0E, 16'hABCD, 8'h00}, 24);
        dsf_host_inst.settle();
        outs();
        bus(0, 4'h0, 0);
        chk("ctrl", 1, rd[1:0]);
        chk("link_frames", m_nlink, n_lk);
        summarize();
    end
endmodule
